//--- rtl/fsi_defines.svh
// Constants for the frequent start supervision block.
// Assumes inclusion by bare name from the design files.
`ifndef FSI_DEFINES_SVH
`define FSI_DEFINES_SVH

// Register byte addresses on the AXI4-Lite slave.
`define FSI_A_CTRL 8'h00
`define FSI_A_HOTLIM 8'h04
`define FSI_A_STCOLD 8'h08
`define FSI_A_STHOT 8'h0c
`define FSI_A_STARTS 8'h10
`define FSI_A_HOURS 8'h14
`define FSI_A_MINGAP 8'h18
`define FSI_A_STATUS 8'h1c
`define FSI_A_COUNT 8'h20
`define FSI_A_IRQST 8'h24
`define FSI_A_IRQCLR 8'h28
`define FSI_A_IRQEN 8'h2c
`define FSI_A_RECSEL 8'h30
`define FSI_A_RECTIME 8'h34
`define FSI_A_RECINFO 8'h38
`define FSI_A_RECINH 8'h3c
`define FSI_A_RECSINCE 8'h40

// Control bit positions.
`define FSI_C_EN 0
`define FSI_C_BLK 1
`define FSI_C_HC 2
`define FSI_C_COLDSET 3

// Reset values of the settings.
`define FSI_R_CTRL 4'hd
`define FSI_R_HOTLIM 10'h2bc
`define FSI_R_STCOLD 13'h0c8
`define FSI_R_STHOT 13'h096
`define FSI_R_NCOLD 7'h03
`define FSI_R_NHOT 7'h02
`define FSI_R_HOURS 7'h01
`define FSI_R_MINGAP 13'h0c8

// Timing: program cycle, clock period, unit conversions.
`define FSI_CLK_NS 10
`define FSI_PROG_NS 1000000
`define FSI_MS_PER_HOUR 32'h0036ee80
`define FSI_MS_PER_TENTH 32'h00000064

// Sizes.
`define FSI_MAX_STARTS 100
`define FSI_RECORDS 12
`define FSI_REC_LAST 4'hb
`define FSI_RESP_OKAY 2'h0
`define FSI_RESP_SLVERR 2'h2

`endif

//--- rtl/fsi_pkg.sv
// Types shared by the frequent start supervision block.
// Assumes nothing of its surroundings.
package fsi_pkg;
    // Bit positions of the six on/off events.
    typedef enum {
        EV_ALARM_ON, EV_ALARM_OFF, EV_INH_ON,
        EV_INH_OFF, EV_BLK_ON, EV_BLK_OFF, EV_COUNT
    } ev_t;
    typedef logic [31:0] word_t;
endpackage : fsi_pkg

//--- rtl/frequent_start_inhibit.sv
// Frequent start supervision: start counter, alarm, inhibit, blocked,
// on/off events, interrupt and a ring of twelve operation records.
// Assumes start, thermal and blocking inputs come from same-clock logic.
`include "fsi_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module frequent_start_inhibit #(
    parameter int unsigned TICK_CYCLES = `FSI_PROG_NS / `FSI_CLK_NS
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic start_i,
    input wire logic [9:0] theta_i,
    input wire logic thermal_en_i,
    input wire logic block_i,
    input wire logic [31:0] timestamp_i,
    output logic alarm_o,
    output logic inhibit_o,
    output logic blocked_o,
    output logic [5:0] event_o,
    output logic irq_o,
    output logic [9:0] hot_limit_o,
    output logic [12:0] stall_cold_o,
    output logic [12:0] stall_hot_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0] ctrl;
    logic [9:0] hot_limit;
    logic [12:0] stall_cold, stall_hot, min_gap;
    logic [6:0] n_cold, n_hot, hours;
    logic [5:0] irq_st, irq_en;
    logic [3:0] rec_sel, rec_wp, rec_cnt;
    logic aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_wr;
    logic [31:0] rd_mux;
    logic rd_err;
    logic [31:0] tick_cnt;
    logic tick;
    logic hot_now, start_ok, enable, blocked, active;
    logic [12:0] stall_cold_eff, stall_cur;
    logic [6:0] allow_cur, used, avail;
    logic [23:0] cnt, next_cnt;
    logic [31:0] acc, frame_ms, acc_sum;
    logic [19:0] decay_add;
    logic dec;
    logic [`FSI_MAX_STARTS-1:0] gt;
    logic [31:0] since_ms, gap_ms, inh_ms;
    logic have_start, gap_hit;
    logic next_alarm, next_inh;
    logic [5:0] next_ev;
    logic [31:0] rec_time [`FSI_RECORDS];
    logic [5:0] rec_ev [`FSI_RECORDS];
    logic [6:0] rec_used [`FSI_RECORDS];
    logic [31:0] rec_inh [`FSI_RECORDS];
    logic [31:0] rec_since [`FSI_RECORDS];
    logic [4:0] rec_idx;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    // Address and data may arrive in either order; each is held until
    // both are present, and nothing more is taken while bvalid stands.
    assign awready_o = !aw_full && !bvalid_o;
    assign wready_o = !w_full && !bvalid_o;
    assign do_wr = aw_full && w_full && !bvalid_o;

    // Holding registers for the write channels.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_full <= 1'b1;
                aw_addr <= awaddr_i;
            end else if (do_wr) begin
                aw_full <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_full <= 1'b1;
                w_data <= wdata_i;
                w_strb <= wstrb_i;
            end else if (do_wr) begin
                w_full <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only addresses answer SLVERR.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            bvalid_o <= 1'b0;
            bresp_o <= `FSI_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_o <= 1'b1;
            case (aw_addr)
                `FSI_A_CTRL, `FSI_A_HOTLIM, `FSI_A_STCOLD, `FSI_A_STHOT,
                `FSI_A_STARTS, `FSI_A_HOURS, `FSI_A_MINGAP,
                `FSI_A_IRQCLR, `FSI_A_IRQEN, `FSI_A_RECSEL:
                    bresp_o <= `FSI_RESP_OKAY;
                default: bresp_o <= `FSI_RESP_SLVERR;
            endcase
        end else if (bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // Byte-lane merge of a write into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    // These hold the motor data once; other functions read the same
    // flops through the export ports, so an edit reaches all of them, except that stall_cold_o shows stall_hot while COLDSET is clear.
    // shared motor data
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            ctrl <= `FSI_R_CTRL;
            hot_limit <= `FSI_R_HOTLIM;
            stall_cold <= `FSI_R_STCOLD;
            stall_hot <= `FSI_R_STHOT;
            n_cold <= `FSI_R_NCOLD;
            n_hot <= `FSI_R_NHOT;
            hours <= `FSI_R_HOURS;
            min_gap <= `FSI_R_MINGAP;
            irq_en <= 6'h00;
            rec_sel <= 4'h0;
        end else if (do_wr) begin
            case (aw_addr)
                `FSI_A_CTRL: ctrl <= 4'(merge(32'(ctrl), w_data, w_strb));
                `FSI_A_HOTLIM:
                    hot_limit <= 10'(merge(32'(hot_limit), w_data, w_strb));
                `FSI_A_STCOLD:
                    stall_cold <= 13'(merge(32'(stall_cold), w_data, w_strb));
                `FSI_A_STHOT:
                    stall_hot <= 13'(merge(32'(stall_hot), w_data, w_strb));
                `FSI_A_STARTS: begin
                    if (w_strb[0]) n_cold <= w_data[6:0];
                    if (w_strb[1]) n_hot <= w_data[14:8];
                end
                `FSI_A_HOURS: hours <= 7'(merge(32'(hours), w_data, w_strb));
                `FSI_A_MINGAP:
                    min_gap <= 13'(merge(32'(min_gap), w_data, w_strb));
                `FSI_A_IRQEN: irq_en <= 6'(merge(32'(irq_en), w_data, w_strb));
                `FSI_A_RECSEL:
                    rec_sel <= 4'(merge(32'(rec_sel), w_data, w_strb));
                default: ;
            endcase
        end
    end

    assign stall_cold_eff = ctrl[`FSI_C_COLDSET] ? stall_cold : stall_hot;
    assign hot_limit_o = hot_limit;
    assign stall_cold_o = stall_cold_eff;
    assign stall_hot_o = stall_hot;

    // ------------------------------------------------------------
    // Program cycle and classification
    // ------------------------------------------------------------
    // One-millisecond program cycle strobe from the system clock.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            tick_cnt <= 32'h0;
        end else if (tick) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end
    assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

    assign hot_now = ctrl[`FSI_C_HC] && thermal_en_i && (theta_i > hot_limit);
    assign stall_cur = hot_now ? stall_hot : stall_cold_eff;
    assign allow_cur = hot_now ? n_hot : n_cold;
    assign enable = ctrl[`FSI_C_EN];
    assign blocked = enable && (ctrl[`FSI_C_BLK] || block_i);
    assign active = enable && !blocked;
    assign start_ok = start_i && enable;

    // ------------------------------------------------------------
    // Start counter
    // ------------------------------------------------------------
    // Decay per millisecond is allowed*stall/frame; a remainder
    // accumulator avoids a divider and loses no fraction.
    assign decay_add = 20'(allow_cur * stall_cur);
    assign frame_ms = 32'(hours * `FSI_MS_PER_HOUR);
    assign acc_sum = acc + 32'(decay_add);
    assign dec = tick && (acc_sum >= frame_ms);

    // Remainder accumulator of the decay.
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !enable) begin
            acc <= 32'h0;
        end else if (dec) begin
            acc <= acc_sum - frame_ms;
        end else if (tick) begin
            acc <= acc_sum;
        end
    end

    always_comb begin
        logic [24:0] s;
        s = {1'b0, cnt} + (start_ok ? 25'(stall_cur) : 25'h0);
        if (dec && s != 25'h0) begin
            s = s - 25'h1;
        end
        next_cnt = s[24] ? 24'hffffff : s[23:0];
    end

    // Counter in tenths of a second of stall stress.
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !enable) begin
            cnt <= 24'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // Starts used: how many whole stall times the counter has begun.
    generate
        for (genvar k = 0; k < `FSI_MAX_STARTS; k++) begin : g_used
            assign gt[k] = {4'h0, cnt} > 28'(k * stall_cur);
        end
    endgenerate
    assign used = 7'($countones(gt));
    assign avail = (used >= allow_cur) ? 7'h00 : allow_cur - used;

    // ------------------------------------------------------------
    // Minimum interval and timers
    // ------------------------------------------------------------
    assign gap_ms = 32'(min_gap * `FSI_MS_PER_TENTH);

    // Time since last start, saturating, in milliseconds.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            since_ms <= 32'h0;
            have_start <= 1'b0;
        end else if (start_ok) begin
            since_ms <= 32'h0;
            have_start <= 1'b1;
        end else if (tick && since_ms != 32'hffffffff) begin
            since_ms <= since_ms + 32'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || !enable) begin
            gap_hit <= 1'b0;
        end else if (start_ok && have_start && since_ms < gap_ms) begin
            gap_hit <= 1'b1;
        end else if (since_ms >= gap_ms) begin
            gap_hit <= 1'b0;
        end
    end

    // Inhibit-on duration, restarted when inhibit rises.
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !inhibit_o) begin
            inh_ms <= 32'h0;
        end else if (tick && inh_ms != 32'hffffffff) begin
            inh_ms <= inh_ms + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Outputs and events
    // ------------------------------------------------------------
    // inhibit when starts are used up or the minimum gap is not kept
    assign next_inh = active && (avail == 7'h00 || gap_hit);
    assign next_alarm = active && avail == 7'h01 && !next_inh;

    always_comb begin
        next_ev = 6'h00;
        next_ev[fsi_pkg::EV_ALARM_ON] = next_alarm && !alarm_o;
        next_ev[fsi_pkg::EV_ALARM_OFF] = !next_alarm && alarm_o;
        next_ev[fsi_pkg::EV_INH_ON] = next_inh && !inhibit_o;
        next_ev[fsi_pkg::EV_INH_OFF] = !next_inh && inhibit_o;
        next_ev[fsi_pkg::EV_BLK_ON] = blocked && !blocked_o;
        next_ev[fsi_pkg::EV_BLK_OFF] = !blocked && blocked_o;
    end

    // Output flops; event pulses line up with the output change.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            alarm_o <= 1'b0;
            inhibit_o <= 1'b0;
            blocked_o <= 1'b0;
            event_o <= 6'h00;
        end else begin
            alarm_o <= next_alarm;
            inhibit_o <= next_inh;
            blocked_o <= blocked;
            event_o <= next_ev;
        end
    end

    // Sticky interrupt status; a new event wins over a clear.
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            irq_st <= 6'h00;
        end else if (do_wr && aw_addr == `FSI_A_IRQCLR && w_strb[0]) begin
            irq_st <= (irq_st & ~w_data[5:0]) | event_o;
        end else begin
            irq_st <= irq_st | event_o;
        end
    end
    assign irq_o = |(irq_st & irq_en);

    // ------------------------------------------------------------
    // Record ring
    // ------------------------------------------------------------
    // twelve newest records
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            rec_wp <= 4'h0;
            rec_cnt <= 4'h0;
        end else if (|event_o) begin
            rec_wp <= (rec_wp == `FSI_REC_LAST) ? 4'h0 : rec_wp + 4'h1;
            if (rec_cnt != `FSI_REC_LAST + 4'h1) begin
                rec_cnt <= rec_cnt + 4'h1;
            end
            rec_time[rec_wp] <= timestamp_i;
            rec_ev[rec_wp] <= event_o;
            rec_used[rec_wp] <= used;
            rec_inh[rec_wp] <= inh_ms;
            rec_since[rec_wp] <= since_ms;
        end
    end

    // Selector 0 reads the newest record, 11 the oldest.
    always_comb begin
        rec_idx = 5'(rec_wp) + 5'(`FSI_REC_LAST) - 5'(rec_sel);
        if (rec_idx > 5'(`FSI_REC_LAST)) begin
            rec_idx = rec_idx - 5'(`FSI_RECORDS);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    // Read data mux; records outside the filled count read as zero.
    always_comb begin
        logic ok;
        ok = rec_sel < rec_cnt;
        rd_mux = 32'h0;
        rd_err = 1'b0;
        case (araddr_i)
            `FSI_A_CTRL: rd_mux = 32'(ctrl);
            `FSI_A_HOTLIM: rd_mux = 32'(hot_limit);
            `FSI_A_STCOLD: rd_mux = 32'(stall_cold);
            `FSI_A_STHOT: rd_mux = 32'(stall_hot);
            `FSI_A_STARTS: rd_mux = {17'h0, n_hot, 1'b0, n_cold};
            `FSI_A_HOURS: rd_mux = 32'(hours);
            `FSI_A_MINGAP: rd_mux = 32'(min_gap);
            `FSI_A_STATUS: rd_mux = {4'h0, rec_cnt, 1'b0, avail, 1'b0,
                used, 3'h0, gap_hit, hot_now, blocked_o, inhibit_o, alarm_o};
            `FSI_A_COUNT: rd_mux = 32'(cnt);
            `FSI_A_IRQST: rd_mux = 32'(irq_st);
            `FSI_A_IRQCLR: rd_mux = 32'h0;
            `FSI_A_IRQEN: rd_mux = 32'(irq_en);
            `FSI_A_RECSEL: rd_mux = 32'(rec_sel);
            `FSI_A_RECTIME: rd_mux = ok ? rec_time[rec_idx[3:0]] : 32'h0;
            `FSI_A_RECINFO: rd_mux = ok ? {17'h0, rec_used[rec_idx[3:0]],
                2'h0, rec_ev[rec_idx[3:0]]} : 32'h0;
            `FSI_A_RECINH: rd_mux = ok ? rec_inh[rec_idx[3:0]] : 32'h0;
            `FSI_A_RECSINCE: rd_mux = ok ? rec_since[rec_idx[3:0]] : 32'h0;
            default: rd_err = 1'b1;
        endcase
    end

    // One read at a time; the answer follows the address by one edge.
    assign arready_o = !rvalid_o;
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            rresp_o <= `FSI_RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rdata_o <= rd_mux;
            rresp_o <= rd_err ? `FSI_RESP_SLVERR : `FSI_RESP_OKAY;
        end else if (rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_alarm;
        @(posedge clock_i) disable iff (!nrst_i)
        (active && avail == 7'h01 && !gap_hit) |=> alarm_o && !inhibit_o;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm missing with one start left");

    property p_inhibit;
        @(posedge clock_i) disable iff (!nrst_i)
        (active && used >= allow_cur) |=> inhibit_o && !alarm_o;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit missing with no start left");

    property p_blocked;
        @(posedge clock_i) disable iff (!nrst_i)
        (enable && block_i) |=> blocked_o && !inhibit_o;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("blocked output missing");

    property p_inh_event;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(inhibit_o) |-> event_o[fsi_pkg::EV_INH_ON]
            ##1 !event_o[fsi_pkg::EV_INH_ON];
    endproperty
    a_inh_event: assert property (p_inh_event)
        else $error("inhibit on event not a single pulse");

    property p_add;
        @(posedge clock_i) disable iff (!nrst_i)
        (start_ok && !tick && !hot_now && cnt < 24'h0fffff)
            |=> cnt == $past(cnt) + 24'($past(stall_cold_eff));
    endproperty
    a_add: assert property (p_add)
        else $error("cold start did not add cold stall time");

    property p_add_hot;
        @(posedge clock_i) disable iff (!nrst_i)
        (start_ok && !tick && hot_now && cnt < 24'h0fffff)
            |=> cnt == $past(cnt) + 24'($past(stall_hot));
    endproperty
    a_add_hot: assert property (p_add_hot)
        else $error("hot start did not add hot stall time");

    property p_early;
        @(posedge clock_i) disable iff (!nrst_i)
        (start_ok && have_start && since_ms < gap_ms && active)
            |=> ##1 inhibit_o;
    endproperty
    a_early: assert property (p_early)
        else $error("early start did not inhibit");

    property p_gap_hold;
        @(posedge clock_i) disable iff (!nrst_i)
        (gap_hit && enable && since_ms + 32'h1 < gap_ms) |=> gap_hit;
    endproperty
    a_gap_hold: assert property (p_gap_hold)
        else $error("gap inhibit released early");

    property p_ring;
        @(posedge clock_i) disable iff (!nrst_i)
        (|event_o && rec_cnt < 4'hc) |=> rec_cnt == $past(rec_cnt) + 4'h1;
    endproperty
    a_ring: assert property (p_ring)
        else $error("record count did not advance");

endmodule : frequent_start_inhibit

`default_nettype wire

//--- verification/motor_stub.sv
// Stand-in for the motor status and thermal overload functions.
// Assumes its request comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module motor_stub (
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic hot_i,
    input wire logic therm_i,
    output logic start_o,
    output logic [9:0] theta_o,
    output logic thermal_en_o
);
    logic go_q = 1'b0;
    // One-cycle start pulse per rising request, like real start detection.
    assign start_o = go_i & ~go_q;
    // Cold sits exactly on the default limit, so a >= slip shows up.
    assign theta_o = hot_i ? 10'h2bd : 10'h2bc;
    // The bench can switch the thermal function off to test classification.
    assign thermal_en_o = therm_i;
    always @(posedge clock_i) go_q <= go_i;
endmodule : motor_stub
`default_nettype wire

//--- verification/tb_frequent_start_inhibit.sv
// Self-checking bench for the frequent start supervision block.
// Assumes the design and the motor stub are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_frequent_start_inhibit;
    logic clock_i = 1'b0, nrst_i = 1'b0, awvalid_i = 1'b0, wvalid_i = 1'b0;
    logic bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0, block_i = 1'b0;
    logic go = 1'b0, hot = 1'b0, start_i, thermal_en_i, awready_o, wready_o;
    logic bvalid_o, arready_o, rvalid_o, alarm_o, inhibit_o, blocked_o, irq_o;
    logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, d;
    logic [9:0] theta_i, hot_limit_o;
    logic [1:0] rresp_o, r, b, bresp_o;
    logic [12:0] stall_cold_o, stall_hot_o;
    logic [5:0] event_o;
    logic therm = 1'b1;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    // Rows: address read after reset, expected data; last one is unmapped.
    localparam logic [7:0] RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
        8'h14, 8'h18, 8'h44};
    localparam logic [31:0] RD [8] = '{32'hd, 32'h2bc, 32'hc8, 32'h96,
        32'h203, 32'h1, 32'hc8, 32'h0};
    frequent_start_inhibit #(.TICK_CYCLES(10)) frequent_start_inhibit_inst (
        .clock_i, .nrst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
        .wstrb_i(4'hf), .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
        .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o,
        .rvalid_o, .rready_i, .start_i, .theta_i, .thermal_en_i, .block_i,
        .timestamp_i(32'h0000_1234), .alarm_o, .inhibit_o, .blocked_o,
        .event_o, .irq_o, .hot_limit_o, .stall_cold_o, .stall_hot_o);
    motor_stub motor_stub_inst (.clock_i, .go_i(go), .hot_i(hot),
        .therm_i(therm), .start_o(start_i), .theta_o(theta_i),
        .thermal_en_o(thermal_en_i));
    always #5 clock_i = ~clock_i;
    // Hang guard: the whole run needs well under 10000 cycles.
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // Extra edge at the end so the next call never reassigns in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr_i <= a;
        wdata_i <= v;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (awready_o) awvalid_i <= 1'b0;
            if (wready_o) wvalid_i <= 1'b0;
        end while (bvalid_o !== 1'b1);
        b = bresp_o;
        bready_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
        output logic [1:0] s);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (arready_o) arvalid_i <= 1'b0;
        end while (rvalid_o !== 1'b1);
        v = rdata_o;
        s = rresp_o;
        rready_i <= 1'b0;
        @(posedge clock_i);
    endtask : rd
    task automatic st(input int n);
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask : st
    task automatic end_of_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // Minimum gap is set to 0.1 s, which is 1000 cycles here.
    initial begin
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        for (int i = 0; i < 8; i++) begin
            rd(RA[i], d, r);
            chk("reg", RD[i], d);
            chk("resp", (i == 7) ? 32'h2 : 32'h0, {30'h0, r});
        end
        chk("hot limit out", 32'h2bc, {22'h0, hot_limit_o});
        chk("hot stall out", 32'h96, {19'h0, stall_hot_o});
        wr(8'h18, 32'h1);
        chk("bresp", 32'h0, {30'h0, b});
        wr(8'h20, 32'h0);
        chk("bresp read-only", 32'h2, {30'h0, b});
        wr(8'h2c, 32'h3f);
        st(1100);
        chk("alarm", 0, alarm_o);
        st(1100);
        chk("alarm", 1, alarm_o);
        chk("irq", 1, irq_o);
        rd(8'h24, d, r);
        chk("irq status", 32'h1, d & 32'h1);
        wr(8'h28, 32'h3f);
        chk("irq", 0, irq_o);
        st(1100);
        chk("inhibit", 1, inhibit_o);
        chk("alarm", 0, alarm_o);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'hd);
        st(10);
        st(10);
        chk("inhibit", 1, inhibit_o);
        repeat (1100) @(posedge clock_i);
        chk("inhibit", 0, inhibit_o);
        chk("alarm", 1, alarm_o);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'hd);
        st(1100);
        chk("alarm", 0, alarm_o);
        hot <= 1'b1;
        wr(8'h00, 32'h0);
        wr(8'h00, 32'hd);
        st(10);
        chk("alarm", 1, alarm_o);
        rd(8'h1c, d, r);
        chk("hot", 32'h8, d & 32'h8);
        therm <= 1'b0;
        rd(8'h1c, d, r);
        chk("hot without thermal", 32'h0, d & 32'h8);
        therm <= 1'b1;
        wr(8'h00, 32'h5);
        chk("cold stall", 32'h96, {19'h0, stall_cold_o});
        block_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("events", 32'h12, {26'h0, event_o});
        repeat (2) @(posedge clock_i);
        chk("blocked", 1, blocked_o);
        rd(8'h38, d, r);
        chk("record info", 32'h112, d);
        rd(8'h34, d, r);
        chk("record time", 32'h1234, d);
        nrst_i <= 1'b0;
        block_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk("blocked in reset", 0, blocked_o);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rd(8'h00, d, r);
        chk("ctrl after reset", 32'hd, d);
        chk("cold stall out", 32'hc8, {19'h0, stall_cold_o});
        end_of_test;
    end
endmodule : tb_frequent_start_inhibit
`default_nettype wire
